// file: ev_cmd_pkg.sv
/*
 Shared constants for the event command link: framing bytes, codes,
 status values, host register map. Assumes byte-wide links both ways.
*/
package ev_cmd_pkg;
   localparam logic [7:0] HDR_CMD     = 8'h03;
   localparam logic [7:0] HDR_RESPONSE_FLAG_BITS    = 8'h0b;
   localparam logic [7:0] CODE_VER    = 8'h40;
   localparam logic [7:0] CODE_MON    = 8'h45;
   localparam logic [7:0] CODE_EVRD   = 8'h47;
   localparam logic [7:0] CODE_EVSET  = 8'h49;
   localparam logic [7:0] LEN_ONE     = 8'h01;
   localparam logic [7:0] LEN_TWO     = 8'h02;
   localparam logic [7:0] LEN_EVRD    = 8'h07;
   localparam logic [7:0] EVSET_EXTRA = 8'h02;
   localparam logic [7:0] ST_REG_OK   = 8'h00;
   localparam logic [7:0] ST_OVR_USED = 8'h01;
   localparam logic [7:0] ST_FULL     = 8'h02;
   localparam logic [7:0] ST_DEL_OK   = 8'h03;
   localparam logic [7:0] ST_DEL_MT   = 8'h04;
   localparam logic [7:0] ST_DEL_NONE = 8'h05;
   localparam int         SLOTS       = 4;
   localparam int         FLAG_BUF    = 0;
   localparam int         FLAG_DEL    = 1;
   localparam int         MON_OFF_BIT = 0;
   localparam logic [7:0] EMB_CODE_AT = 8'h04;
   localparam int         RESPONSE_FLAG_BITS_MAX    = 9;
   localparam int         TX_DEPTH    = 16;
   localparam int         RX_DEPTH    = 8;
   localparam logic [7:0] A_CTRL      = 8'h00;
   localparam logic [7:0] A_TXD       = 8'h04;
   localparam logic [7:0] A_STAT      = 8'h08;
   localparam logic [7:0] A_MASK      = 8'h0c;
   localparam logic [7:0] A_RXLEN     = 8'h10;
   localparam logic [7:0] A_RXD0      = 8'h20;
   localparam int         CTRL_START  = 8;
   localparam int         CTRL_ABORT  = 31;
   localparam int         ST_DONE     = 0;
   localparam int         ST_BADHDR   = 1;
endpackage

// file: ev_link_if.sv
/*
 Byte link between host end and device end, valid/ready each way.
 Assumes both ends share mclk.
*/
`timescale 1ns/1ps
interface ev_link_if;
   logic [7:0] h2d_data;
   logic       h2d_valid;
   logic       h2d_ready;
   logic [7:0] d2h_data;
   logic       d2h_valid;
   logic       d2h_ready;
   modport device (input h2d_data, h2d_valid, d2h_ready,
                   output h2d_ready, d2h_data, d2h_valid);
   modport host   (output h2d_data, h2d_valid, d2h_ready,
                   input h2d_ready, d2h_data, d2h_valid);
endinterface

// file: ev_dev.sv
/*
 Device end: parses framed instructions, keeps four event slots and the
 run monitor setting, returns framed responses.
 Assumes one clock mclk and a host keeping to valid/ready.
*/
`timescale 1ns/1ps
module ev_dev #(
   parameter logic [7:0] VERSION = 8'h12 // Arbitrary value
) (
   input  wire logic         mclk,
   input  wire logic         rstn,
   ev_link_if.device         lnk,
   input  wire logic         run_in,
   input  wire logic         pulse_active,
   input  wire logic         override_busy,
   input  wire logic         ev_take,
   output logic              pulse_hold,
   output logic              run_ignore_flag,
   output logic [2:0]        ev_count,
   output logic [1:0]        ev_next_idx,
   output logic [31:0]       ev_codes,
   output logic [3:0]        ev_buf_sel
);
   typedef enum logic [2:0] {S_HDR, S_LEN, S_BODY, S_EXEC, S_RESPONSE_FLAG_BITS} dst_t;
   dst_t       st_r;
   logic [7:0] len_r;
   logic [7:0] idx_r;
   logic [7:0] code_r;
   logic [7:0] flags_r;
   logic [7:0] emb_code_r;
   logic       monitor_r;
   logic [2:0] count_r;
   logic [1:0] next_r;
   logic [7:0] slot_r [ev_cmd_pkg::SLOTS];
   logic [3:0] sel_r;
   logic [7:0] response_flag_bits_r [ev_cmd_pkg::RESPONSE_FLAG_BITS_MAX];
   logic [3:0] rn_r;
   logic [3:0] ri_r;
   logic       rx_take;
   logic       last_body;
   logic       tx_take;
   logic       do_set;
   logic       del_req;
   logic [7:0] set_status;
   logic [7:0] next_num;
   logic       known_code;

   assign rx_take   = lnk.h2d_valid && lnk.h2d_ready;
   assign last_body = (idx_r + 8'h01 == len_r);
   assign tx_take   = lnk.d2h_valid && lnk.d2h_ready;
   assign lnk.h2d_ready = (st_r == S_HDR) || (st_r == S_LEN) || (st_r == S_BODY);
   assign lnk.d2h_valid = (st_r == S_RESPONSE_FLAG_BITS);
   assign lnk.d2h_data  = response_flag_bits_r[ri_r];
   assign do_set   = (st_r == S_EXEC) && (code_r == ev_cmd_pkg::CODE_EVSET);
   assign del_req  = flags_r[ev_cmd_pkg::FLAG_DEL];
   assign next_num = (count_r == 3'd0) ? 8'h00 : {6'd0, next_r} + 8'h01;
   // Decided from the code, since rn_r only loads at the same edge
   assign known_code = (code_r == ev_cmd_pkg::CODE_VER) || (code_r == ev_cmd_pkg::CODE_MON)
                       || (code_r == ev_cmd_pkg::CODE_EVSET) || (code_r == ev_cmd_pkg::CODE_EVRD);

   always_comb begin
      if (del_req) begin
         if (count_r == 3'd0)
            set_status = ev_cmd_pkg::ST_DEL_NONE;
         else if (count_r == 3'd1)
            set_status = ev_cmd_pkg::ST_DEL_MT;
         else
            set_status = ev_cmd_pkg::ST_DEL_OK;
      end else if (count_r == 3'(ev_cmd_pkg::SLOTS)) begin
         set_status = ev_cmd_pkg::ST_FULL;
      end else if (override_busy) begin
         set_status = ev_cmd_pkg::ST_OVR_USED;
      end else begin
         set_status = ev_cmd_pkg::ST_REG_OK;
      end
   end

   // Frame receive and sequencing
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         st_r  <= S_HDR;
         len_r <= 8'h00;
         idx_r <= 8'h00;
      end else begin
         case (st_r)
            S_HDR: begin
               if (rx_take && lnk.h2d_data == ev_cmd_pkg::HDR_CMD)
                  st_r <= S_LEN;
            end
            S_LEN: begin
               if (rx_take) begin
                  len_r <= lnk.h2d_data;
                  idx_r <= 8'h00;
                  st_r  <= (lnk.h2d_data == 8'h00) ? S_HDR : S_BODY;
               end
            end
            S_BODY: begin
               if (rx_take) begin
                  idx_r <= idx_r + 8'h01;
                  if (last_body)
                     st_r <= S_EXEC;
               end
            end
            S_EXEC: begin
               st_r <= known_code ? S_RESPONSE_FLAG_BITS : S_HDR;
            end
            S_RESPONSE_FLAG_BITS: begin
               if (tx_take && ri_r + 4'd1 == rn_r)
                  st_r <= S_HDR;
            end
            default: st_r <= S_HDR;
         endcase
      end
   end

   // Captured body fields; embedded code sits after header and length
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         code_r     <= 8'h00;
         flags_r    <= 8'h00;
         emb_code_r <= 8'h00;
      end else if (st_r == S_LEN && rx_take) begin
         flags_r    <= 8'h00;
         emb_code_r <= 8'h00;
      end else if (st_r == S_BODY && rx_take) begin
         if (idx_r == 8'h00)
            code_r <= lnk.h2d_data;
         if (idx_r == 8'h01)
            flags_r <= lnk.h2d_data;
         if (idx_r == ev_cmd_pkg::EMB_CODE_AT)
            emb_code_r <= lnk.h2d_data;
      end
   end

   // Run monitor setting; no data byte means monitoring off
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         monitor_r <= 1'b1;
      end else if (st_r == S_EXEC && code_r == ev_cmd_pkg::CODE_MON) begin
         if (len_r >= ev_cmd_pkg::LEN_TWO)
            monitor_r <= !flags_r[ev_cmd_pkg::MON_OFF_BIT];
         else
            monitor_r <= 1'b0;
      end
   end

   assign pulse_hold      = monitor_r && pulse_active && !run_in;
   assign run_ignore_flag = !monitor_r;

   // Event slots
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         count_r <= 3'd0;
         sel_r   <= 4'h0;
         for (int i = 0; i < ev_cmd_pkg::SLOTS; i++)
            slot_r[i] <= 8'h00;
      end else if (do_set && del_req) begin
         if (count_r != 3'd0) begin
            count_r <= count_r - 3'd1;
            slot_r[count_r[1:0] - 2'd1] <= 8'h00;
            sel_r[count_r[1:0] - 2'd1]  <= 1'b0;
         end
      end else if (do_set && set_status == ev_cmd_pkg::ST_REG_OK) begin
         slot_r[count_r[1:0]] <= emb_code_r;
         sel_r[count_r[1:0]]  <= flags_r[ev_cmd_pkg::FLAG_BUF];
         count_r              <= count_r + 3'd1;
      end
   end

   // Next slot to run; pulled back if deletion passes it
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         next_r <= 2'd0;
      end else if (do_set && del_req && count_r != 3'd0) begin
         if ({1'b0, next_r} >= count_r - 3'd1)
            next_r <= (count_r <= 3'd1) ? 2'd0 : 2'(count_r - 3'd2);
      end else if (ev_take && {1'b0, next_r} + 3'd1 < count_r) begin
         next_r <= next_r + 2'd1;
      end
   end

   // Response build and send
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         rn_r <= 4'd0;
         ri_r <= 4'd0;
         for (int i = 0; i < ev_cmd_pkg::RESPONSE_FLAG_BITS_MAX; i++)
            response_flag_bits_r[i] <= 8'h00;
      end else if (st_r == S_EXEC) begin
         ri_r      <= 4'd0;
         response_flag_bits_r[0] <= ev_cmd_pkg::HDR_RESPONSE_FLAG_BITS;
         response_flag_bits_r[2] <= code_r;
         case (code_r)
            ev_cmd_pkg::CODE_VER: begin
               response_flag_bits_r[1] <= ev_cmd_pkg::LEN_TWO;
               response_flag_bits_r[3] <= VERSION;
               rn_r      <= 4'd4;
            end
            ev_cmd_pkg::CODE_MON: begin
               response_flag_bits_r[1] <= ev_cmd_pkg::LEN_ONE;
               rn_r      <= 4'd3;
            end
            ev_cmd_pkg::CODE_EVSET: begin
               response_flag_bits_r[1] <= ev_cmd_pkg::LEN_TWO;
               response_flag_bits_r[3] <= set_status;
               rn_r      <= 4'd4;
            end
            ev_cmd_pkg::CODE_EVRD: begin
               response_flag_bits_r[1] <= ev_cmd_pkg::LEN_EVRD;
               response_flag_bits_r[3] <= {5'd0, count_r};
               response_flag_bits_r[4] <= next_num;
               for (int i = 0; i < ev_cmd_pkg::SLOTS; i++)
                  response_flag_bits_r[5 + i] <= slot_r[i];
               rn_r      <= 4'd9;
            end
            default: rn_r <= 4'd0;
         endcase
      end else if (tx_take) begin
         ri_r <= ri_r + 4'd1;
      end
   end

   assign ev_count    = count_r;
   assign ev_next_idx = next_r;
   assign ev_buf_sel  = sel_r;
   assign ev_codes    = {slot_r[3], slot_r[2], slot_r[1], slot_r[0]};
endmodule

// file: ev_host.sv
/*
 Host end: Wishbone classic slave holding a transmit byte array, a
 receive byte array and interrupt status/mask; frames and sends an
 instruction, then captures the response.
 Assumes single-cycle Wishbone masters and one clock mclk.
*/
`timescale 1ns/1ps
module ev_host (
   input  wire logic         mclk,
   input  wire logic         rstn,
   ev_link_if.host           lnk,
   input  wire logic         wb_cyc_i,
   input  wire logic         wb_stb_i,
   input  wire logic         wb_we_i,
   input  wire logic [7:0]   wb_adr_i,
   input  wire logic [31:0]  wb_dat_i,
   input  wire logic [3:0]   wb_sel_i,
   output logic [31:0]       wb_dat_o,
   output logic              wb_ack_o,
   output logic              irq
);
   typedef enum logic [2:0] {H_IDLE, H_HDR, H_LEN, H_BODY,
                             H_RHDR, H_RLEN, H_RBODY} hst_t;
   hst_t       st_r;
   logic [7:0] tx_r [ev_cmd_pkg::TX_DEPTH];
   logic [7:0] rx_r [ev_cmd_pkg::RX_DEPTH];
   logic [3:0] wp_r;
   logic [7:0] len_r;
   logic [7:0] ti_r;
   logic [7:0] rlen_r;
   logic [7:0] ri_r;
   logic [1:0] stat_r;
   logic [1:0] mask_r;
   logic       acc;
   logic       wr;
   logic       start;
   logic       abort;
   logic       tx_take;
   logic       rx_take;

   assign acc     = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr      = acc && wb_we_i;
   assign start   = wr && wb_adr_i == ev_cmd_pkg::A_CTRL && wb_sel_i[1]
                    && wb_dat_i[ev_cmd_pkg::CTRL_START] && st_r == H_IDLE
                    && wb_dat_i[7:0] != 8'h00;
   assign abort   = wr && wb_adr_i == ev_cmd_pkg::A_CTRL && wb_sel_i[3]
                    && wb_dat_i[ev_cmd_pkg::CTRL_ABORT];
   assign tx_take = lnk.h2d_valid && lnk.h2d_ready;
   assign rx_take = lnk.d2h_valid && lnk.d2h_ready;
   assign lnk.h2d_valid = (st_r == H_HDR) || (st_r == H_LEN) || (st_r == H_BODY);
   assign lnk.d2h_ready = (st_r == H_RHDR) || (st_r == H_RLEN) || (st_r == H_RBODY);
   assign irq = |(stat_r & mask_r);

   always_comb begin
      case (st_r)
         H_HDR:   lnk.h2d_data = ev_cmd_pkg::HDR_CMD;
         H_LEN:   lnk.h2d_data = len_r;
         default: lnk.h2d_data = tx_r[ti_r[3:0]];
      endcase
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         st_r   <= H_IDLE;
         ti_r   <= 8'h00;
         ri_r   <= 8'h00;
         rlen_r <= 8'h00;
         len_r  <= 8'h00;
      end else if (abort) begin
         st_r <= H_IDLE;
      end else begin
         case (st_r)
            H_IDLE: if (start) begin
               len_r <= wb_dat_i[7:0];
               ti_r  <= 8'h00;
               st_r  <= H_HDR;
            end
            H_HDR:  if (tx_take) st_r <= H_LEN;
            H_LEN:  if (tx_take) st_r <= H_BODY;
            H_BODY: if (tx_take) begin
               ti_r <= ti_r + 8'h01;
               if (ti_r + 8'h01 == len_r)
                  st_r <= H_RHDR;
            end
            H_RHDR: if (rx_take) st_r <= H_RLEN;
            H_RLEN: if (rx_take) begin
               rlen_r <= lnk.d2h_data;
               ri_r   <= 8'h00;
               st_r   <= (lnk.d2h_data == 8'h00) ? H_IDLE : H_RBODY;
            end
            H_RBODY: if (rx_take) begin
               ri_r <= ri_r + 8'h01;
               if (ri_r + 8'h01 == rlen_r)
                  st_r <= H_IDLE;
            end
            default: st_r <= H_IDLE;
         endcase
      end
   end

   // Byte arrays; receive bytes past the array depth are dropped
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         wp_r <= 4'd0;
         for (int i = 0; i < ev_cmd_pkg::TX_DEPTH; i++)
            tx_r[i] <= 8'h00;
         for (int i = 0; i < ev_cmd_pkg::RX_DEPTH; i++)
            rx_r[i] <= 8'h00;
      end else begin
         if (start)
            wp_r <= 4'd0;
         else if (wr && wb_adr_i == ev_cmd_pkg::A_TXD && wb_sel_i[0] && st_r == H_IDLE) begin
            tx_r[wp_r] <= wb_dat_i[7:0];
            wp_r       <= wp_r + 4'd1;
         end
         if (st_r == H_RBODY && rx_take && ri_r < 8'(ev_cmd_pkg::RX_DEPTH))
            rx_r[ri_r[2:0]] <= lnk.d2h_data;
      end
   end

   // Sticky status: hardware set wins over a write-one clear
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         stat_r <= 2'b00;
         mask_r <= 2'b00;
      end else begin
         if (wr && wb_adr_i == ev_cmd_pkg::A_MASK && wb_sel_i[0])
            mask_r <= wb_dat_i[1:0];
         stat_r <= (stat_r & ~((wr && wb_adr_i == ev_cmd_pkg::A_STAT && wb_sel_i[0])
                               ? wb_dat_i[1:0] : 2'b00))
                   | {st_r == H_RHDR && rx_take && lnk.d2h_data != ev_cmd_pkg::HDR_RESPONSE_FLAG_BITS,
                      (st_r == H_RLEN && rx_take && lnk.d2h_data == 8'h00)
                      || (st_r == H_RBODY && rx_take && ri_r + 8'h01 == rlen_r)};
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= acc;
         if (acc && !wb_we_i) begin
            if (wb_adr_i == ev_cmd_pkg::A_CTRL)
               wb_dat_o <= {23'd0, st_r != H_IDLE, len_r};
            else if (wb_adr_i == ev_cmd_pkg::A_STAT)
               wb_dat_o <= {30'd0, stat_r};
            else if (wb_adr_i == ev_cmd_pkg::A_MASK)
               wb_dat_o <= {30'd0, mask_r};
            else if (wb_adr_i == ev_cmd_pkg::A_RXLEN)
               wb_dat_o <= {24'd0, rlen_r};
            else if (wb_adr_i >= ev_cmd_pkg::A_RXD0 && wb_adr_i[7:5] == 3'd1
                     && wb_adr_i[1:0] == 2'd0)
               wb_dat_o <= {24'd0, rx_r[wb_adr_i[4:2]]};
            else
               wb_dat_o <= 32'h0000_0000;
         end
      end
   end
endmodule

// file: ev_link_chk.sv
/*
 Checker for the byte link between host end and device end, plus the
 run monitor outputs. Assumes one clock mclk and async active-low rstn.
*/
`timescale 1ns/1ps
module ev_link_chk (
   input wire logic       mclk,
   input wire logic       rstn,
   input wire logic [7:0] h2d_data,
   input wire logic       h2d_valid,
   input wire logic       h2d_ready,
   input wire logic [7:0] d2h_data,
   input wire logic       d2h_valid,
   input wire logic       d2h_ready,
   input wire logic       run_in,
   input wire logic       pulse_active,
   input wire logic       pulse_hold,
   input wire logic       run_ignore_flag
);
   logic [7:0] hidx_r;
   logic [7:0] hlen_r;
   logic [7:0] icode_r;
   logic [7:0] didx_r;
   logic [7:0] dlen_r;
   logic [7:0] exp_len;
   logic       h_take;
   logic       d_take;
   logic       h_last;
   logic       d_last;

   assign h_take = h2d_valid && h2d_ready;
   assign d_take = d2h_valid && d2h_ready;
   // Frame ends follow the length byte only
   assign h_last = h_take && hidx_r >= 8'h02 && hidx_r == hlen_r + 8'h01;
   assign d_last = d_take && didx_r >= 8'h02 && didx_r == dlen_r + 8'h01;

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         hidx_r  <= 8'h00;
         hlen_r  <= 8'h00;
         icode_r <= 8'h00;
      end else if (h_take) begin
         hidx_r <= h_last ? 8'h00 : hidx_r + 8'h01;
         if (hidx_r == 8'h01) hlen_r <= h2d_data;
         if (hidx_r == 8'h02) icode_r <= h2d_data;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         didx_r <= 8'h00;
         dlen_r <= 8'h00;
      end else if (d_take) begin
         didx_r <= d_last ? 8'h00 : didx_r + 8'h01;
         if (didx_r == 8'h01) dlen_r <= d2h_data;
      end
   end

   always_comb begin
      case (icode_r)
         8'h40:   exp_len = 8'h02;
         8'h45:   exp_len = 8'h01;
         8'h47:   exp_len = 8'h07;
         default: exp_len = 8'h02;
      endcase
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);

   sequence s_instr_end;
      h_last;
   endsequence
   sequence s_response_flag_bits_begin;
      !d2h_valid ##1 (d2h_valid && didx_r == 8'h00);
   endsequence

   a_response_flag_bits_delay: assert property (s_instr_end |=> s_response_flag_bits_begin)
      else $error("response start not two cycles after instruction end");
   a_inst_hdr: assert property (h2d_valid && hidx_r == 8'h00 |-> h2d_data == 8'h03)
      else $error("instruction header wrong");
   a_response_flag_bits_hdr: assert property (d2h_valid && didx_r == 8'h00 |-> d2h_data == 8'h0b)
      else $error("response header wrong");
   a_response_flag_bits_len: assert property (d_take && didx_r == 8'h01 |-> d2h_data == exp_len)
      else $error("response length wrong");
   a_response_flag_bits_code: assert property (
      d_take && didx_r == 8'h02 |-> d2h_data == icode_r)
      else $error("response code differs from instruction code");
   a_set_status: assert property (
      d_take && didx_r == 8'h03 && icode_r == 8'h49 |-> d2h_data <= 8'h05)
      else $error("event set status out of range");
   a_response_flag_bits_stable: assert property (
      d2h_valid && !d2h_ready |=> d2h_valid && $stable(d2h_data))
      else $error("response byte dropped before taken");
   a_hold_on: assert property (pulse_active && !run_in && !run_ignore_flag |-> pulse_hold)
      else $error("pulse not held while run low");
   a_hold_off: assert property (run_ignore_flag |-> !pulse_hold)
      else $error("pulse held with monitoring off");
   a_hold_cause: assert property (pulse_hold |-> pulse_active && !run_in)
      else $error("pulse held without cause");
   a_flag_reset: assert property ($rose(rstn) |-> !run_ignore_flag)
      else $error("monitoring not on after reset");
endmodule

// file: test_pulse_ctrl_event_cmd_handler.sv
/*
 Testbench joining host end and device end over the link interface.
 Assumes Wishbone ack one cycle after the request is taken.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
   $display("Error at %0t: got %h exp %h", $time, g, e); end end
module test_pulse_ctrl_event_cmd_handler;
   typedef struct packed {
      logic [7:0]  len;
      logic [39:0] body;
      logic        ovr;
      logic [7:0]  rlen;
      logic [7:0]  rcode;
      logic [7:0]  rst;
      logic [2:0]  cnt;
   } row_t;
   localparam logic [7:0] VER = 8'h5a; // Arbitrary value
   localparam int NROWS = 17;
   // Count byte of a read shares the status column
   localparam row_t rows [NROWS] = '{
      '{8'h01, 40'h4000000000, 1'h0, 8'h02, 8'h40, VER, 3'h0},
      '{8'h02, 40'h4902000000, 1'h0, 8'h02, 8'h49, 8'h05, 3'h0},
      '{8'h05, 40'h49000301c1, 1'h0, 8'h02, 8'h49, 8'h00, 3'h1},
      '{8'h05, 40'h49010301c9, 1'h1, 8'h02, 8'h49, 8'h01, 3'h1},
      '{8'h05, 40'h49010301c2, 1'h0, 8'h02, 8'h49, 8'h00, 3'h2},
      '{8'h05, 40'h49000301c3, 1'h0, 8'h02, 8'h49, 8'h00, 3'h3},
      '{8'h05, 40'h49010301c4, 1'h0, 8'h02, 8'h49, 8'h00, 3'h4},
      '{8'h05, 40'h49000301c5, 1'h1, 8'h02, 8'h49, 8'h02, 3'h4},
      '{8'h01, 40'h4700000000, 1'h0, 8'h07, 8'h47, 8'h04, 3'h4},
      '{8'h02, 40'h4902000000, 1'h0, 8'h02, 8'h49, 8'h03, 3'h3},
      '{8'h01, 40'h4700000000, 1'h0, 8'h07, 8'h47, 8'h03, 3'h3},
      '{8'h02, 40'h4902000000, 1'h0, 8'h02, 8'h49, 8'h03, 3'h2},
      '{8'h02, 40'h4902000000, 1'h0, 8'h02, 8'h49, 8'h03, 3'h1},
      '{8'h02, 40'h4902000000, 1'h0, 8'h02, 8'h49, 8'h04, 3'h0},
      '{8'h02, 40'h4902000000, 1'h0, 8'h02, 8'h49, 8'h05, 3'h0},
      '{8'h01, 40'h4700000000, 1'h0, 8'h07, 8'h47, 8'h00, 3'h0},
      '{8'h01, 40'h4500000000, 1'h0, 8'h01, 8'h45, 8'h00, 3'h0}};

   logic        mclk = 1'b0;
   logic        rstn = 1'b0;
   logic        run_in = 1'b1;
   logic        pulse_active = 1'b0;
   logic        override_busy = 1'b0;
   logic        ev_take = 1'b0;
   logic        cyc = 1'b0;
   logic        stb = 1'b0;
   logic        we = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic        ack;
   logic        irq;
   logic        pulse_hold;
   logic        run_ignore_flag;
   logic [2:0]  ev_count;
   logic [1:0]  ev_next_idx;
   logic [31:0] ev_codes;
   logic [3:0]  ev_buf_sel;
   logic [7:0]  rx [8];
   logic [7:0]  rl;
   int          error_cnt = 0;
   int          comparisons = 0;

   ev_link_if lnk ();
   ev_dev #(.VERSION(VER)) u_ev_dev (.mclk(mclk), .rstn(rstn), .lnk(lnk), .run_in(run_in),
      .pulse_active(pulse_active), .override_busy(override_busy), .ev_take(ev_take),
      .pulse_hold(pulse_hold), .run_ignore_flag(run_ignore_flag), .ev_count(ev_count),
      .ev_next_idx(ev_next_idx), .ev_codes(ev_codes), .ev_buf_sel(ev_buf_sel));
   ev_host u_ev_host (.mclk(mclk), .rstn(rstn), .lnk(lnk), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hf), .wb_dat_o(rdat),
      .wb_ack_o(ack), .irq(irq));
   ev_link_chk u_ev_link_chk (.mclk(mclk), .rstn(rstn), .h2d_data(lnk.h2d_data),
      .h2d_valid(lnk.h2d_valid), .h2d_ready(lnk.h2d_ready), .d2h_data(lnk.d2h_data),
      .d2h_valid(lnk.d2h_valid), .d2h_ready(lnk.d2h_ready), .run_in(run_in),
      .pulse_active(pulse_active), .pulse_hold(pulse_hold),
      .run_ignore_flag(run_ignore_flag));

   always #5 mclk = ~mclk;

   task automatic conclude();
      $display("mismatches %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
      int n;
      n = 0;
      @(posedge mclk);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      do begin
         @(posedge mclk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (ack !== 1'b1) begin
         error_cnt++;
         conclude();
      end
   endtask

   // Send one instruction, wait for the interrupt, fetch the response
   task automatic xfer(input row_t r);
      logic [31:0] q;
      int          n;
      override_busy <= r.ovr;
      for (n = 0; n < r.len; n++)
         wb(1'b1, ev_cmd_pkg::A_TXD, {24'h0, r.body[39-8*n -: 8]}, q);
      wb(1'b1, ev_cmd_pkg::A_CTRL, {23'h0, 1'b1, r.len}, q);
      n = 0;
      while (irq !== 1'b1 && n < 300) begin
         @(posedge mclk);
         n++;
      end
      if (irq !== 1'b1) begin
         error_cnt++;
         conclude();
      end
      wb(1'b0, ev_cmd_pkg::A_RXLEN, 32'h0, q);
      rl = q[7:0];
      for (n = 0; n < 8; n++) begin
         wb(1'b0, ev_cmd_pkg::A_RXD0 + 8'(4 * n), 32'h0, q);
         rx[n] = q[7:0];
      end
      wb(1'b1, ev_cmd_pkg::A_STAT, 32'h1, q);
   endtask

   initial begin
      logic [31:0] q;
      int          i;
      int          j;
      repeat (8) @(posedge mclk);
      rstn <= 1'b1;
      @(posedge mclk);
      `CHK(run_ignore_flag, 1'b0)
      `CHK(ev_count, 3'h0)
      wb(1'b1, ev_cmd_pkg::A_MASK, 32'h1, q);
      for (i = 0; i < NROWS; i++) begin
         xfer(rows[i]);
         `CHK(rl, rows[i].rlen)
         `CHK(rx[0], rows[i].rcode)
         if (rows[i].rlen > 8'h01) `CHK(rx[1], rows[i].rst)
         `CHK(ev_count, rows[i].cnt)
         if (rows[i].body[39:32] == 8'h47) begin
            `CHK(rx[2], 8'(rows[i].cnt != 3'h0))
            for (j = 0; j < rows[i].cnt; j++) `CHK(rx[3+j], 8'hc1 + 8'(j))
         end
         if (i == 6) begin
            `CHK(ev_codes, 32'hc4c3c2c1)
            `CHK(ev_buf_sel, 4'ha)
         end
      end
      @(posedge mclk);
      `CHK(irq, 1'b0)
      `CHK(run_ignore_flag, 1'b1)
      run_in <= 1'b0;
      pulse_active <= 1'b1;
      repeat (2) @(posedge mclk);
      `CHK(pulse_hold, 1'b0)
      // Data byte with bit0 clear turns monitoring back on
      xfer(row_t'{8'h02, 40'h4500000000, 1'h0, 8'h01, 8'h45, 8'h00, 3'h0});
      `CHK(pulse_hold, 1'b1)
      xfer(rows[16]);
      `CHK(pulse_hold, 1'b0)
      // Reset in mid-run brings monitoring back
      rstn <= 1'b0;
      repeat (2) @(posedge mclk);
      rstn <= 1'b1;
      repeat (2) @(posedge mclk);
      `CHK(run_ignore_flag, 1'b0)
      `CHK(pulse_hold, 1'b1)
      run_in <= 1'b1;
      repeat (2) @(posedge mclk);
      `CHK(pulse_hold, 1'b0)
      wb(1'b1, ev_cmd_pkg::A_MASK, 32'h1, q);
      xfer(rows[2]);
      xfer(rows[4]);
      ev_take <= 1'b1;
      @(posedge mclk);
      ev_take <= 1'b0;
      @(posedge mclk);
      `CHK(ev_next_idx, 2'h1)
      xfer(rows[8]);
      `CHK(rx[1], 8'h02)
      `CHK(rx[2], 8'h02)
      // Masked done must not raise the interrupt
      wb(1'b1, ev_cmd_pkg::A_MASK, 32'h0, q);
      wb(1'b1, ev_cmd_pkg::A_TXD, 32'h40, q);
      wb(1'b1, ev_cmd_pkg::A_CTRL, 32'h101, q);
      j = 0;
      do begin
         wb(1'b0, ev_cmd_pkg::A_STAT, 32'h0, q);
         j++;
      end while (q[0] !== 1'b1 && j < 40);
      `CHK(q[0], 1'b1)
      `CHK(irq, 1'b0)
      wb(1'b1, ev_cmd_pkg::A_STAT, 32'h1, q);
      wb(1'b0, ev_cmd_pkg::A_STAT, 32'h0, q);
      `CHK(q[0], 1'b0)
      wb(1'b0, 8'h3c, 32'h0, q);
      `CHK(q, 32'h0)
      conclude();
   end
endmodule
